/* File: owbio_byte_io.sv */
// Byte-level write, read and single-bit commands of the single-wire master.
// Overview of operation
// [RULE1] The single-bit value is bit 7 of the parameter; other bits are ignored.
// [RULE2] A slave sending zero pulls low during our low phase; one never holds low.
// [RULE3] Read slots use exactly the write-one low-phase timing.
// [RULE4] Code A5h plus one data byte writes that byte on the line.
// [RULE5] Busy at write code: neither code nor data byte acknowledged, command dropped.
// [RULE6] Write activity starts within 262.5 ns of the data byte's last bit.
// [RULE7] Bytes go out least significant bit first, after the whole byte arrived.
// [RULE8] Write byte takes eight slots plus margin; busy stays set eight slots.
// [RULE9] Accepting write or read byte leaves the read pointer on status.
// [RULE10] Code 96h reads eight slots and stores the byte in read data.
// [RULE11] Every read-byte slot is a write-one slot.
// [RULE12] Busy at read code: code not acknowledged, command ignored.
// [RULE13] Read activity starts within 262.5 ns of the code ack; busy eight slots.
// [RULE14] Host points at read data before reading the captured byte.
// [RULE15] Speed and active pullup apply to all slots; strong pullup to writes only. The code also applies it after single-bit commands.
// [RULE16] Slot value zero makes write-zero, one makes write-one or read slot.
module owbio_byte_io (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_link_clk,
  input  wire owbio_pkg::owbio_host_ev_t i_host_ev,
  input  wire logic                      i_speed_select,
  input  wire logic                      i_active_pullup_enable,
  input  wire logic                      i_strong_pullup_enable,
  input  wire logic                      i_line_in,
  output logic                           o_cmd_ack,
  output logic                           o_param_ack,
  output logic                           o_line_busy_flag,
  output logic                           o_ptr_to_status_ff,
  output logic [7:0]                     o_read_data_ff,
  output logic                           o_single_bit_result_ff,
  output logic                           o_line_out_ff,
  output logic                           o_line_oe_ff
);
  import owbio_pkg::*;

  owbio_state_t state_ff;
  owbio_req_t   req_ff;
  logic [7:0]   pend_code_ff;
  logic         param_owed_ff;
  logic         req_tgl_ff;
  logic         dn_meta_ff;
  logic         dn_sync_ff;
  logic         dn_seen_ff;
  logic         dn_tgl_ff;
  logic [7:0]   rx_ff;
  logic         done_edge;
  logic         code_known;
  logic         accept;
  logic         launch;
  owbio_req_t   nxt_req;

  // Reference-clock side: command decode and busy.
  assign code_known = (i_host_ev.cmd_code == CMD_WRITE_BYTE)
                      || (i_host_ev.cmd_code == CMD_READ_BYTE)
                      || (i_host_ev.cmd_code == CMD_SINGLE_BIT);
  assign o_line_busy_flag = (state_ff == ST_RUN);
  // [RULE5] Refuse when busy.
  // [RULE12] Read code refused.
  assign accept    = i_host_ev.cmd_valid && (state_ff == ST_IDLE) && code_known;
  assign o_cmd_ack = accept;
  assign o_param_ack = i_host_ev.byte_valid && param_owed_ff;
  assign done_edge = dn_sync_ff ^ dn_seen_ff;

  // [RULE4] Write byte launch.
  // [RULE7] Whole byte first.
  // [RULE13] Read starts at ack.
  always_comb begin
    launch = 1'b0;
    if (accept && i_host_ev.cmd_code == CMD_READ_BYTE) begin
      launch = 1'b1;
    end else if (state_ff == ST_WAIT_PARAM) begin
      if (pend_code_ff == CMD_WRITE_BYTE) begin
        launch = i_host_ev.byte_valid;
      end else begin
        launch = i_host_ev.first_bit_valid;
      end
    end
  end

  // [RULE15] Options per command.
  // [RULE1] Value from bit 7.
  always_comb begin
    nxt_req.is_read = (state_ff == ST_IDLE);
    nxt_req.single  = (state_ff == ST_WAIT_PARAM) && (pend_code_ff == CMD_SINGLE_BIT);
    nxt_req.speed   = i_speed_select;
    nxt_req.active_pullup_enable     = i_active_pullup_enable;
    nxt_req.strong_pullup_enable     = i_strong_pullup_enable && (state_ff == ST_WAIT_PARAM);
    if (state_ff == ST_IDLE) begin
      nxt_req.bits = READ_SLOT_BITS;
    end else if (pend_code_ff == CMD_WRITE_BYTE) begin
      nxt_req.bits = i_host_ev.byte_data;
    end else begin
      nxt_req.bits = {7'h00, i_host_ev.first_bit};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (launch) begin
            state_ff <= ST_RUN;
          end else if (accept) begin
            state_ff <= ST_WAIT_PARAM;
          end
        end
        ST_WAIT_PARAM: begin
          if (launch) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (done_edge) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pend_code_ff  <= 8'h00;
      param_owed_ff <= 1'b0;
    end else begin
      if (accept) begin
        pend_code_ff <= i_host_ev.cmd_code;
      end
      if (accept && i_host_ev.cmd_code != CMD_READ_BYTE) begin
        param_owed_ff <= 1'b1;
      end else if (i_host_ev.byte_valid) begin
        param_owed_ff <= 1'b0;
      end
    end
  end

  // [RULE9] Pointer to status.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ptr_to_status_ff <= 1'b0;
    end else begin
      o_ptr_to_status_ff <= accept;
    end
  end

  // The request word is held still until the link side answers, so it crosses safely.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      req_ff     <= '0;
      req_tgl_ff <= 1'b0;
    end else if (launch) begin
      req_ff     <= nxt_req;
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    dn_meta_ff <= dn_tgl_ff;
    dn_sync_ff <= dn_meta_ff;
  end

  // [RULE10] Store read byte.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dn_seen_ff             <= 1'b0;
      o_read_data_ff         <= 8'h00;
      o_single_bit_result_ff <= 1'b0;
    end else begin
      dn_seen_ff <= dn_sync_ff;
      if (done_edge && req_ff.is_read) begin
        o_read_data_ff <= rx_ff;
      end
      if (done_edge && req_ff.single) begin
        o_single_bit_result_ff <= rx_ff[7];
      end
    end
  end

  // Link-clock side: slot sequencing and pins.
  logic            lrst_meta_ff;
  logic            lrst_ff;
  logic            rq_meta_ff;
  logic            rq_sync_ff;
  logic            rq_seen_ff;
  logic            ln_meta_ff;
  logic            ln_sync_ff;
  logic            req_edge;
  logic            run_ff;
  logic [3:0]      left_ff;
  logic [7:0]      bits_ff;
  logic            spu_on_ff;
  owbio_req_t      cur_ff;
  owbio_slot_tim_t tim_ff;
  logic            slot_start;
  logic            slot_value;
  logic            drive_low;
  logic            drive_high;
  logic            slot_done;
  logic            slot_sample;

  always_ff @(posedge i_link_clk) begin
    lrst_meta_ff <= i_rst;
    lrst_ff      <= lrst_meta_ff;
    rq_meta_ff   <= req_tgl_ff;
    rq_sync_ff   <= rq_meta_ff;
    ln_meta_ff   <= i_line_in;
    ln_sync_ff   <= ln_meta_ff;
  end

  assign req_edge   = rq_sync_ff ^ rq_seen_ff;
  // [RULE6] Start on arrival.
  assign slot_start = req_edge || (run_ff && slot_done && left_ff != 4'h1);
  // [RULE7] Least bit first.
  // [RULE11] Read slots send one.
  assign slot_value = req_edge ? req_ff.bits[0] : bits_ff[1];

  // [RULE8] Eight back-to-back slots.
  always_ff @(posedge i_link_clk) begin
    if (lrst_ff) begin
      rq_seen_ff <= 1'b0;
      run_ff     <= 1'b0;
      left_ff    <= 4'h0;
      bits_ff    <= 8'h00;
      rx_ff      <= 8'h00;
      dn_tgl_ff  <= 1'b0;
      cur_ff     <= '0;
      tim_ff     <= '0;
    end else begin
      rq_seen_ff <= rq_sync_ff;
      if (req_edge) begin
        run_ff  <= 1'b1;
        left_ff <= req_ff.single ? 4'h1 : 4'(BYTE_SLOTS);
        bits_ff <= req_ff.bits;
        cur_ff  <= req_ff;
        tim_ff  <= slot_timing(req_ff.speed);
      end else if (run_ff && slot_done) begin
        bits_ff <= {1'b0, bits_ff[7:1]};
        rx_ff   <= {slot_sample, rx_ff[7:1]};
        left_ff <= left_ff - 4'h1;
        if (left_ff == 4'h1) begin
          run_ff    <= 1'b0;
          dn_tgl_ff <= ~dn_tgl_ff;
        end
      end
    end
  end

  // [RULE15] Strong pullup after write byte and single bit.
  // It holds the line high until the next request reaches the link side, when the slots need it released.
  always_ff @(posedge i_link_clk) begin
    if (lrst_ff) begin
      spu_on_ff <= 1'b0;
    end else if (req_edge) begin
      spu_on_ff <= 1'b0;
    end else if (run_ff && slot_done && left_ff == 4'h1) begin
      spu_on_ff <= cur_ff.strong_pullup_enable && !cur_ff.is_read;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (lrst_ff) begin
      o_line_oe_ff  <= 1'b0;
      o_line_out_ff <= 1'b0;
    end else begin
      o_line_oe_ff  <= drive_low || drive_high || spu_on_ff;
      o_line_out_ff <= !drive_low && (drive_high || spu_on_ff);
    end
  end

  // [RULE2] Sample slave reply.
  owbio_slot u_slot (
    .i_link_clk   (i_link_clk),
    .i_link_rst   (lrst_ff),
    .i_start      (slot_start),
    .i_value      (slot_value),
    .i_tim        (tim_ff),
    .i_apu        (cur_ff.active_pullup_enable),
    .i_line_sync  (ln_sync_ff),
    .o_drive_low  (drive_low),
    .o_drive_high (drive_high),
    .o_done       (slot_done),
    .o_sample_ff  (slot_sample)
  );

  property p_busy_write_refused;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_host_ev.cmd_valid && o_line_busy_flag && i_host_ev.cmd_code == CMD_WRITE_BYTE
      |-> !o_cmd_ack ##1 !param_owed_ff;
  endproperty
  a_busy_write_refused: assert property (p_busy_write_refused) // [RULE5]
    else $error("Write code acknowledged while busy.");

  property p_busy_read_refused;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_host_ev.cmd_valid && o_line_busy_flag && i_host_ev.cmd_code == CMD_READ_BYTE
      |-> !o_cmd_ack ##1 $stable(req_tgl_ff);
  endproperty
  a_busy_read_refused: assert property (p_busy_read_refused) // [RULE12]
    else $error("Read code acted on while busy.");

  property p_ptr_status;
    @(posedge i_ref_clk) disable iff (i_rst)
      accept |=> o_ptr_to_status_ff;
  endproperty
  a_ptr_status: assert property (p_ptr_status) // [RULE9]
    else $error("Read pointer not returned to status.");

  property p_write_launch;
    @(posedge i_ref_clk) disable iff (i_rst)
      state_ff == ST_WAIT_PARAM && pend_code_ff == CMD_WRITE_BYTE && i_host_ev.byte_valid
      |=> o_line_busy_flag && req_ff.bits == $past(i_host_ev.byte_data);
  endproperty
  a_write_launch: assert property (p_write_launch) // [RULE4]
    else $error("Write data byte not launched.");

  property p_busy_holds;
    @(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_line_busy_flag) |-> o_line_busy_flag [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds) // [RULE8]
    else $error("Busy dropped too early.");

  property p_read_launch;
    @(posedge i_ref_clk) disable iff (i_rst)
      accept && i_host_ev.cmd_code == CMD_READ_BYTE
      |=> o_line_busy_flag && req_ff.bits == READ_SLOT_BITS;
  endproperty
  a_read_launch: assert property (p_read_launch) // [RULE13]
    else $error("Read byte not launched at once.");

  property p_activity_start;
    @(posedge i_link_clk) disable iff (lrst_ff)
      req_edge |-> ##2 (o_line_oe_ff && !o_line_out_ff);
  endproperty
  a_activity_start: assert property (p_activity_start) // [RULE6]
    else $error("Line activity did not start promptly.");

  property p_lsb_first;
    @(posedge i_link_clk) disable iff (lrst_ff)
      run_ff && slot_done && left_ff != 4'h1
      |-> slot_value == cur_ff.bits[3'(4'(BYTE_SLOTS) + 4'h1 - left_ff)];
  endproperty
  a_lsb_first: assert property (p_lsb_first) // [RULE7]
    else $error("Bit order on the line is wrong.");

  property p_spu_write_only;
    @(posedge i_link_clk) disable iff (lrst_ff)
      $rose(spu_on_ff) |-> !cur_ff.is_read && cur_ff.strong_pullup_enable;
  endproperty
  a_spu_write_only: assert property (p_spu_write_only) // [RULE15]
    else $error("Strong pullup after a read.");

endmodule : owbio_byte_io

/* File: owbio_pkg.sv */
// Package with commands, slot timing and carrier types of the single-wire byte engine.
package owbio_pkg;

  localparam logic [7:0] CMD_WRITE_BYTE  = 8'hA5;
  localparam logic [7:0] CMD_READ_BYTE   = 8'h96;
  localparam logic [7:0] CMD_SINGLE_BIT  = 8'h87;
  localparam int         PARAM_VALUE_BIT = 7;
  localparam int         BYTE_SLOTS      = 8;
  localparam logic [7:0] READ_SLOT_BITS  = 8'hFF;

  localparam int REF_CLK_PERIOD_PS  = 10000;
  localparam int LINK_CLK_PERIOD_PS = 30000;
  localparam int START_LATENCY_PS   = 262500;
  localparam int START_LATENCY_CYC  = START_LATENCY_PS / REF_CLK_PERIOD_PS;

  // Slot times in ns; the speed_select input picks the fast set.
  localparam int STD_SLOT_PERIOD_NS     = 70000;
  localparam int STD_WRITE_ZERO_LOW_NS  = 60000;
  localparam int STD_WRITE_ONE_LOW_NS   = 6000;
  localparam int STD_SAMPLE_NS          = 12000;
  localparam int FAST_SLOT_PERIOD_NS    = 10000;
  localparam int FAST_WRITE_ZERO_LOW_NS = 7500;
  localparam int FAST_WRITE_ONE_LOW_NS  = 1000;
  localparam int FAST_SAMPLE_NS         = 1700;
  localparam int ACTIVE_PULLUP_NS       = 300;

  localparam int SLOT_CNT_W = 12;

  function automatic logic [SLOT_CNT_W-1:0] cyc_ceil(input int ns);
    cyc_ceil = SLOT_CNT_W'((ns * 1000 + LINK_CLK_PERIOD_PS - 1) / LINK_CLK_PERIOD_PS);
  endfunction : cyc_ceil

  function automatic logic [SLOT_CNT_W-1:0] cyc_floor(input int ns);
    cyc_floor = SLOT_CNT_W'((ns * 1000) / LINK_CLK_PERIOD_PS);
  endfunction : cyc_floor

  typedef struct packed {
    logic [SLOT_CNT_W-1:0] slot_period;
    logic [SLOT_CNT_W-1:0] write_zero_low_time;
    logic [SLOT_CNT_W-1:0] write_one_low_time;
    logic [SLOT_CNT_W-1:0] sample_time;
    logic [SLOT_CNT_W-1:0] pullup_time;
  } owbio_slot_tim_t;

  function automatic owbio_slot_tim_t slot_timing(input logic fast);
    owbio_slot_tim_t t;
    t.slot_period         = cyc_ceil(fast ? FAST_SLOT_PERIOD_NS : STD_SLOT_PERIOD_NS);
    t.write_zero_low_time = cyc_ceil(fast ? FAST_WRITE_ZERO_LOW_NS : STD_WRITE_ZERO_LOW_NS);
    t.write_one_low_time  = cyc_floor(fast ? FAST_WRITE_ONE_LOW_NS : STD_WRITE_ONE_LOW_NS);
    t.sample_time         = cyc_floor(fast ? FAST_SAMPLE_NS : STD_SAMPLE_NS);
    t.pullup_time         = cyc_ceil(ACTIVE_PULLUP_NS);
    slot_timing = t;
  endfunction : slot_timing

  // Byte events from the bridge's host-side receiver, all on the reference clock.
  typedef struct packed {
    logic       cmd_valid;
    logic [7:0] cmd_code;
    logic       first_bit_valid;
    logic       first_bit;
    logic       byte_valid;
    logic [7:0] byte_data;
  } owbio_host_ev_t;

  typedef struct packed {
    logic       is_read;
    logic       single;
    logic [7:0] bits;
    logic       speed;
    logic       active_pullup_enable;
    logic       strong_pullup_enable;
  } owbio_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_PARAM,
    ST_RUN
  } owbio_state_t;

endpackage : owbio_pkg

/* File: owbio_slot.sv */
// One single-wire time slot generator on the link clock.
module owbio_slot (
  input  wire logic                       i_link_clk,
  input  wire logic                       i_link_rst,
  input  wire logic                       i_start,
  input  wire logic                       i_value,
  input  wire owbio_pkg::owbio_slot_tim_t i_tim,
  input  wire logic                       i_apu,
  input  wire logic                       i_line_sync,
  output logic                            o_drive_low,
  output logic                            o_drive_high,
  output logic                            o_done,
  output logic                            o_sample_ff
);
  import owbio_pkg::*;

  logic                  active_ff;
  logic                  value_ff;
  logic [SLOT_CNT_W-1:0] cnt_ff;
  logic [SLOT_CNT_W-1:0] low_len;

  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      active_ff <= 1'b0;
      cnt_ff    <= '0;
    end else if (i_start) begin
      active_ff <= 1'b1;
      cnt_ff    <= '0;
    end else if (active_ff) begin
      if (cnt_ff == i_tim.slot_period - 1'b1) begin
        active_ff <= 1'b0;
      end
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      value_ff <= 1'b1;
    end else if (i_start) begin
      value_ff <= i_value;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      o_sample_ff <= 1'b1;
    end else if (active_ff && cnt_ff == i_tim.sample_time) begin
      o_sample_ff <= i_line_sync;
    end
  end

  // [RULE3] Shared low phase.
  // A read slot is a write-one slot, so only the value picks the low length.
  // [RULE16] Value picks slot.
  assign low_len      = value_ff ? i_tim.write_one_low_time : i_tim.write_zero_low_time;
  assign o_drive_low  = active_ff && (cnt_ff < low_len);
  assign o_drive_high = active_ff && i_apu && (cnt_ff >= low_len)
                        && (cnt_ff < low_len + i_tim.pullup_time);
  assign o_done       = active_ff && (cnt_ff == i_tim.slot_period - 1'b1);

  property p_one_low_len;
    @(posedge i_link_clk) disable iff (i_link_rst)
      active_ff && value_ff && cnt_ff == i_tim.write_one_low_time - 1'b1
      |-> o_drive_low ##1 !o_drive_low;
  endproperty
  a_one_low_len: assert property (p_one_low_len) // [RULE3]
    else $error("Write-one low phase has the wrong length.");

  property p_zero_low_len;
    @(posedge i_link_clk) disable iff (i_link_rst)
      active_ff && !value_ff && cnt_ff == i_tim.write_zero_low_time - 1'b1
      |-> o_drive_low ##1 !o_drive_low;
  endproperty
  a_zero_low_len: assert property (p_zero_low_len) // [RULE16]
    else $error("Write-zero low phase has the wrong length.");

endmodule : owbio_slot

/* File: owbio_slave_model.sv */
// Behavioural single-wire slave that answers read slots and decodes written bits.
module owbio_slave_model (
  input  wire logic        i_mst_low,
  input  wire logic        i_clear,
  input  wire logic [7:0]  i_tx_byte,
  input  wire logic [15:0] i_hold_ns,
  input  wire logic [15:0] i_thresh_ns,
  output logic             o_pull_low,
  output logic [7:0]       o_rx_byte,
  output logic [15:0]      o_bits,
  output logic [15:0]      o_low_min,
  output logic [15:0]      o_low_max
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime t_fall;
  int      dt;
  initial o_pull_low = 1'b0;
  always @(posedge i_clear) begin
    o_bits = 16'h0000;
    o_low_min = 16'hFFFF;
    o_low_max = 16'h0000;
    o_rx_byte = 8'h00;
  end
  // Zero pulls low for i_hold_ns from the master's falling edge.
  // A one never touches the line, so only the pull-up raises it.
  always @(posedge i_mst_low) begin
    t_fall = $realtime;
    if (i_tx_byte[o_bits[2:0]] == 1'b0) begin
      o_pull_low = 1'b1;
      #(i_hold_ns) o_pull_low = 1'b0;
    end
  end
  always @(negedge i_mst_low) begin
    dt = int'($realtime - t_fall);
    o_rx_byte = {dt < int'(i_thresh_ns), o_rx_byte[7:1]};
    o_bits = o_bits + 16'h0001;
    if (dt < int'(o_low_min)) o_low_min = 16'(dt);
    if (dt > int'(o_low_max)) o_low_max = 16'(dt);
  end
endmodule : owbio_slave_model

/* File: tb_single_wire_byte_io.sv */
// Self-checking bench of the single-wire byte engine against a slave model.
module tb_single_wire_byte_io;
  timeunit 1ns;
  timeprecision 1ps;
  import owbio_pkg::*;
  typedef struct packed {
    logic       rd;
    logic       fast;
    logic       active_pullup_enable;
    logic       strong_pullup_enable;
    logic [7:0] data;
    logic       oe_end;
  } owbio_row_t;
  localparam owbio_row_t ROWS [4] = '{
    '{1'b0, 1'b1, 1'b0, 1'b0, 8'h5A, 1'b0},
    '{1'b1, 1'b1, 1'b1, 1'b1, 8'hC3, 1'b0},
    '{1'b0, 1'b1, 1'b1, 1'b1, 8'h01, 1'b1},
    '{1'b1, 1'b0, 1'b0, 1'b0, 8'h96, 1'b0}};
  logic           ref_clk, link_clk, rst, speed, active_pullup_enable, strong_pullup_enable, line_in, clr;
  logic           cmd_ack, param_ack, busy, ptr, bit_res, line_out, line_oe;
  logic           pull_low, busy_q, apu_seen, mst_low;
  logic [7:0]     rd_data, tx_byte, rx_byte;
  logic [15:0]    hold_ns, n_bits, lo_min, lo_max;
  owbio_host_ev_t ev;
  int             mismatches, checked, slot, w1;
  realtime        t_rise, t_ev;
  assign mst_low = line_oe && !line_out;
  // The line has a pull-up: high unless someone pulls it low.
  assign line_in = !(mst_low || pull_low);
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge ref_clk) begin
    if (busy === 1'b1 && busy_q !== 1'b1) t_rise = $realtime;
    busy_q <= busy;
  end
  always @(posedge link_clk) begin
    if (busy === 1'b1 && line_oe === 1'b1 && line_out === 1'b1) apu_seen = 1'b1;
  end
  owbio_byte_io dut_u (.i_ref_clk(ref_clk), .i_rst(rst), .i_link_clk(link_clk),
    .i_host_ev(ev), .i_speed_select(speed), .i_active_pullup_enable(active_pullup_enable),
    .i_strong_pullup_enable(strong_pullup_enable), .i_line_in(line_in), .o_cmd_ack(cmd_ack),
    .o_param_ack(param_ack), .o_line_busy_flag(busy), .o_ptr_to_status_ff(ptr),
    .o_read_data_ff(rd_data), .o_single_bit_result_ff(bit_res),
    .o_line_out_ff(line_out), .o_line_oe_ff(line_oe));
  owbio_slave_model slave_u (.i_mst_low(mst_low), .i_clear(clr), .i_tx_byte(tx_byte),
    .i_hold_ns(hold_ns), .i_thresh_ns(hold_ns), .o_pull_low(pull_low),
    .o_rx_byte(rx_byte), .o_bits(n_bits), .o_low_min(lo_min), .o_low_max(lo_max));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send_cmd(input logic [7:0] code, input logic acc);
    @(posedge ref_clk);
    #1 ev.cmd_valid = 1'b1;
    ev.cmd_code = code;
    #1 chk("cmd_ack", 16'(acc), 16'(cmd_ack));
    @(posedge ref_clk);
    t_ev = $realtime;
    #1 ev.cmd_valid = 1'b0;
    chk("ptr_to_status", 16'(acc), 16'(ptr));
  endtask : send_cmd
  task automatic send_par(input logic first, input logic [7:0] d, input logic acc);
    @(posedge ref_clk);
    #1 ev.first_bit_valid = first;
    ev.first_bit = d[7];
    ev.byte_valid = !first;
    ev.byte_data = d;
    #1 if (!first) chk("param_ack", 16'(acc), 16'(param_ack));
    @(posedge ref_clk);
    t_ev = $realtime;
    #1 ev.first_bit_valid = 1'b0;
    ev.byte_valid = 1'b0;
  endtask : send_par
  task automatic start_chk;
    for (int n = 0; n < 400 && mst_low !== 1'b1; n++) #1;
    chk("start_in_margin", 16'h0001, 16'(($realtime - t_ev) <= 262.5));
    apu_seen = 1'b0;
  endtask : start_chk
  task automatic busy_chk(input int slots);
    realtime span;
    for (int n = 0; n < 70000 && busy !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    span = $realtime - 1 - t_rise;
    chk("busy_low_bound", 16'h0001, 16'(span >= slots * slot));
    chk("busy_high_bound", 16'h0001, 16'(span <= slots * slot + 1000));
  endtask : busy_chk
  task automatic setup(input logic fast);
    speed = fast;
    hold_ns = fast ? 16'd3000 : 16'd20000;
    slot = fast ? 10000 : 70000;
    w1 = fast ? 990 : 6000;
    #1 clr = 1'b1;
    #1 clr = 1'b0;
  endtask : setup
  task automatic summarize;
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  initial begin
    // The slots take about 0.82 ms in all; a hang stops at 1 ms, after 100k reference cycles.
    #1000000;
    mismatches++;
    $display("Watchdog expired");
    summarize();
  end
  initial begin
    ev = '0;
    {speed, active_pullup_enable, strong_pullup_enable, clr, apu_seen} = 5'b10000;
    tx_byte = 8'hFF;
    hold_ns = 16'd3000;
    mismatches = 0;
    checked = 0;
    rst = 1'b1;
    // Four edges suffice: the link side still gets one reset edge via its synchroniser.
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (20) @(posedge ref_clk);
    send_cmd(8'h00, 1'b0);
    for (int r = 0; r < 4; r++) begin
      setup(ROWS[r].fast);
      active_pullup_enable = ROWS[r].active_pullup_enable;
      strong_pullup_enable = ROWS[r].strong_pullup_enable;
      tx_byte = ROWS[r].rd ? ROWS[r].data : 8'hFF;
      send_cmd(ROWS[r].rd ? CMD_READ_BYTE : CMD_WRITE_BYTE, 1'b1);
      if (!ROWS[r].rd) send_par(1'b0, ROWS[r].data, 1'b1);
      start_chk();
      send_cmd(CMD_WRITE_BYTE, 1'b0);
      send_par(1'b0, 8'h3C, 1'b0);
      send_cmd(CMD_READ_BYTE, 1'b0);
      busy_chk(8);
      chk("slot_count", 16'd8, n_bits);
      if (ROWS[r].rd) begin
        chk("read_data", 16'(ROWS[r].data), 16'(rd_data));
        chk("read_low_min", 16'(w1), lo_min);
        chk("read_low_max", 16'(w1), lo_max);
      end else begin
        chk("written_byte", 16'(ROWS[r].data), 16'(rx_byte));
      end
      chk("active_pullup", 16'(ROWS[r].active_pullup_enable), 16'(apu_seen));
      repeat (30) @(posedge ref_clk);
      #1 chk("strong_pullup", 16'(ROWS[r].oe_end), 16'(line_oe & line_out));
      $display("Row %0d finished", r);
    end
    // The slave answers one, so only the slot value decides the sampled bit.
    tx_byte = 8'hFF;
    for (int v = 0; v < 2; v++) begin
      setup(1'b1);
      send_cmd(CMD_SINGLE_BIT, 1'b1);
      send_par(1'b1, v ? 8'h80 : 8'h7F, 1'b0);
      start_chk();
      send_par(1'b0, v ? 8'h80 : 8'h7F, 1'b1);
      busy_chk(1);
      chk("bit_low_time", v ? 16'd990 : 16'd7500, lo_max);
      chk("bit_result", 16'(v), 16'(bit_res));
      $display("Single bit %0d finished", v);
    end
    send_cmd(CMD_READ_BYTE, 1'b1);
    repeat (100) @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1 chk("reset_busy", 16'h0000, 16'(busy));
    chk("reset_read_data", 16'h0000, 16'(rd_data));
    chk("reset_line_oe", 16'h0000, 16'(line_oe));
    rst = 1'b0;
    $display("Mid-run reset finished");
    summarize();
  end
endmodule : tb_single_wire_byte_io
